// >>> core/mailbox_pkg.sv
// Shared constants, types and index decoders for the host/EC mailbox
package mailbox_pkg;

    // Storage
    localparam int unsigned MBX_COUNT = 43;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Host access port offsets
    localparam logic PORT_OFF_INDEX = 1'b0;
    localparam logic PORT_OFF_DATA = 1'b1;

    // Index values of the signalling registers
    localparam logic [7:0] IDX_H2E = 8'h82;
    localparam logic [7:0] IDX_E2H = 8'h83;
    localparam logic [7:0] IDX_SMI_SRC = 8'h96;
    localparam logic [7:0] IDX_SMI_MASK = 8'h97;

    // Index runs of the general mailbox bytes
    localparam logic [7:0] IDX_RUN0_LO = 8'h84;
    localparam logic [7:0] IDX_RUN0_HI = 8'h95;
    localparam logic [7:0] IDX_PAIR_LO = 8'h98;
    localparam logic [7:0] IDX_PAIR_HI = 8'h99;
    localparam logic [7:0] IDX_SOLO0 = 8'h9b;
    localparam logic [7:0] IDX_SOLO1 = 8'h9d;
    localparam logic [7:0] IDX_SOLO2 = 8'h9f;
    localparam logic [7:0] IDX_RUN1_LO = 8'ha0;
    localparam logic [7:0] IDX_RUN1_HI = 8'hb3;
    localparam logic [5:0] SLOT_PAIR = 6'h12;
    localparam logic [5:0] SLOT_SOLO0 = 6'h14;
    localparam logic [5:0] SLOT_SOLO1 = 6'h15;
    localparam logic [5:0] SLOT_SOLO2 = 6'h16;
    localparam logic [5:0] SLOT_RUN1 = 6'h17;

    // EC direct byte offsets
    localparam logic [7:0] EC_OFF_H2E = 8'h00;
    localparam logic [7:0] EC_OFF_E2H = 8'h04;
    localparam logic [7:0] EC_OFF_SRC = 8'h08;
    localparam logic [7:0] EC_OFF_MASK = 8'h0c;
    localparam logic [7:0] EC_OFF_MBX = 8'h10;
    localparam logic [7:0] EC_OFF_MBX_END = 8'h3b;

    // Command register values
    localparam logic [7:0] CMD_CLEAR_VAL = 8'hff;
    localparam logic [7:0] CMD_CLEARED = 8'h00;

    // SMI source / mask fields
    localparam int unsigned SMI_WR_BIT = 0;
    localparam int unsigned SMI_SWI_LSB = 1;
    localparam int unsigned SMI_SWI_MSB = 7;

    // Serial IRQ frames
    localparam int unsigned FRAME_COUNT = 16;

    typedef struct packed {
        logic wr;
        logic addr;
        logic [7:0] data;
    } host_req_t;

    typedef struct packed {
        logic h2e;
        logic e2h;
        logic src;
        logic mask;
        logic ec_command_irq;
        logic [5:0] slot;
    } sel_t;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b01,
        LINK_WAIT = 2'b10
    } link_state_t;

    function automatic sel_t decode_index(input logic [7:0] idx);
        sel_t s;
        s = '0;
        case (idx)
            IDX_H2E: s.h2e = 1'b1;
            IDX_E2H: s.e2h = 1'b1;
            IDX_SMI_SRC: s.src = 1'b1;
            IDX_SMI_MASK: s.mask = 1'b1;
            IDX_PAIR_LO, IDX_PAIR_HI: begin
                s.ec_command_irq = 1'b1;
                s.slot = 6'(idx - IDX_PAIR_LO) + SLOT_PAIR;
            end
            IDX_SOLO0: begin
                s.ec_command_irq = 1'b1;
                s.slot = SLOT_SOLO0;
            end
            IDX_SOLO1: begin
                s.ec_command_irq = 1'b1;
                s.slot = SLOT_SOLO1;
            end
            IDX_SOLO2: begin
                s.ec_command_irq = 1'b1;
                s.slot = SLOT_SOLO2;
            end
            default: begin
                if (idx >= IDX_RUN0_LO && idx <= IDX_RUN0_HI) begin
                    s.ec_command_irq = 1'b1;
                    s.slot = 6'(idx - IDX_RUN0_LO);
                end else if (idx >= IDX_RUN1_LO && idx <= IDX_RUN1_HI) begin
                    s.ec_command_irq = 1'b1;
                    s.slot = 6'(idx - IDX_RUN1_LO) + SLOT_RUN1;
                end
            end
        endcase
        return s;
    endfunction : decode_index

    function automatic sel_t decode_ec(input logic [7:0] off);
        sel_t s;
        s = '0;
        case (off)
            EC_OFF_H2E: s.h2e = 1'b1;
            EC_OFF_E2H: s.e2h = 1'b1;
            EC_OFF_SRC: s.src = 1'b1;
            EC_OFF_MASK: s.mask = 1'b1;
            default: begin
                if (off >= EC_OFF_MBX && off < EC_OFF_MBX_END) begin
                    s.ec_command_irq = 1'b1;
                    s.slot = 6'(off - EC_OFF_MBX);
                end
            end
        endcase
        return s;
    endfunction : decode_ec

endpackage : mailbox_pkg

// >>> core/host_ec_mailbox.sv
// Host/EC mailbox: host port on the link clock, register file and events on the system clock
`timescale 1ns/1ps

// Function
// - Forty-seven byte registers by index: 43 shared bytes, four signalling registers.
// - Host port has index register at offset 0 and data register at offset 1.
// - Host writes index first; data port then transfers the selected register.
// - EC can also reach the index/data port from its own side.
// - Host write of host-to-EC command raises EC command interrupt when unmasked.
// - Host write of data port raises separate EC data interrupt.
// - EC writing FFh to host-to-EC command at its direct offset clears it to 00h; through the index/data port FFh is stored.
// - Host writing FFh to EC-to-host command clears it to 00h.
// - EC write of EC-to-host command at its direct offset can raise host SMI when enabled.
// - Serial IRQ source asserts while EC-wrote flag and its enable are set.
// - SMI source asserts on any enabled soft bit or enabled EC-wrote flag.
// - SMI event placeable in any selectable serial IRQ frame.
// - SMI drives the open-drain alert pin low.
// - Alert pin carries SMI only when its pin function is selected.
// - Main-well reset returns all registers and logic to defaults.
// - Host power-good low resets index and data registers to zero.
// - Register file and event logic run from the system clock; host port runs from the link clock.
// - Block idles into low power with no software request.
// - Index 82h, 83h, 96h, 97h select command and SMI registers; 84h-95h, 98h, 99h, 9Bh, 9Dh, 9Fh, A0h-B3h are bytes.
// - Index 9Ah, 9Ch, 9Eh are reserved and select nothing.
module host_ec_mailbox
    import mailbox_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_clk_link,
    input wire logic i_host_req,
    input wire logic i_host_wr,
    input wire logic i_host_addr,
    input wire logic [7:0] i_host_wdata,
    output logic [7:0] o_host_rdata,
    output logic o_host_done,
    output logic o_host_busy,
    input wire logic i_host_power_good,
    input wire logic i_ec_req,
    input wire logic i_ec_wrote_flag,
    input wire logic i_ec_port_sel,
    input wire logic [7:0] i_ec_addr,
    input wire logic [7:0] i_ec_wdata,
    output logic [7:0] o_ec_rdata,
    output logic o_ec_ack,
    input wire logic i_ec_cmd_irq_en,
    input wire logic [1:0] i_ec_irq_clr,
    output logic o_ec_command_irq,
    output logic o_ec_data_irq,
    output logic o_host_serirq_source,
    output logic o_host_smi_source,
    input wire logic [3:0] i_smi_frame_sel,
    output logic [FRAME_COUNT-1:0] o_smi_frame_vec,
    input wire logic i_alert_pin_sel,
    output logic o_host_alert_pin_out,
    output logic o_host_alert_pin_oe,
    output logic o_low_power
);

    // ---------------- Link domain: host I/O cycles ----------------
    link_state_t link_state_q, link_state_d;
    host_req_t link_req_q, link_req_d;
    logic req_tgl_q, req_tgl_d;
    logic ack_sync1_q, ack_sync2_q;
    logic [7:0] host_rdata_q, host_rdata_d;
    logic host_done_q, host_done_d;
    logic host_busy_q, host_busy_d;

    // Sys domain handshake state read across
    logic ack_tgl_q, ack_tgl_d;
    logic [7:0] rsp_q, rsp_d;

    always_comb begin
        link_state_d = link_state_q;
        link_req_d = link_req_q;
        req_tgl_d = req_tgl_q;
        host_rdata_d = host_rdata_q;
        host_done_d = 1'b0;
        case (link_state_q)
            LINK_IDLE: begin
                if (i_host_req) begin
                    link_req_d = '{wr: i_host_wr, addr: i_host_addr, data: i_host_wdata};
                    req_tgl_d = ~req_tgl_q;
                    link_state_d = LINK_WAIT;
                end
            end
            LINK_WAIT: begin
                // Request and its data stay frozen until the answer returns
                if (ack_sync2_q == req_tgl_q) begin
                    host_rdata_d = rsp_q;
                    host_done_d = 1'b1;
                    link_state_d = LINK_IDLE;
                end
            end
            default: link_state_d = LINK_IDLE;
        endcase
        host_busy_d = (link_state_d == LINK_WAIT);
    end

    always_ff @(posedge i_clk_link or negedge i_rst_b) begin
        if (!i_rst_b) begin
            link_state_q <= LINK_IDLE;
            link_req_q <= '0;
            req_tgl_q <= 1'b0;
            ack_sync1_q <= 1'b0;
            ack_sync2_q <= 1'b0;
            host_rdata_q <= RST_BYTE;
            host_done_q <= 1'b0;
            host_busy_q <= 1'b0;
        end else begin
            link_state_q <= link_state_d;
            link_req_q <= link_req_d;
            req_tgl_q <= req_tgl_d;
            ack_sync1_q <= ack_tgl_q;
            ack_sync2_q <= ack_sync1_q;
            host_rdata_q <= host_rdata_d;
            host_done_q <= host_done_d;
            host_busy_q <= host_busy_d;
        end
    end

    assign o_host_rdata = host_rdata_q;
    assign o_host_done = host_done_q;
    assign o_host_busy = host_busy_q;

    // ---------------- Sys domain: synchronisers ----------------
    logic req_sync1_q, req_sync2_q;
    logic host_power_good_sync1_q, host_power_good_sync2_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            req_sync1_q <= 1'b0;
            req_sync2_q <= 1'b0;
            host_power_good_sync1_q <= 1'b0;
            host_power_good_sync2_q <= 1'b0;
        end else begin
            req_sync1_q <= req_tgl_q;
            req_sync2_q <= req_sync1_q;
            host_power_good_sync1_q <= i_host_power_good;
            host_power_good_sync2_q <= host_power_good_sync1_q;
        end
    end

    // ---------------- Sys domain: register file ----------------
    logic [7:0] index_q, index_d;
    logic [7:0] data_q, data_d;
    logic [7:0] h2e_q, h2e_d;
    logic [7:0] e2h_q, e2h_d;
    logic [7:0] src_q, src_d;
    logic [7:0] mask_q, mask_d;
    logic [7:0] mbx_q [MBX_COUNT];
    logic [7:0] mbx_d [MBX_COUNT];
    logic cmd_pend_q, cmd_pend_d;
    logic data_pend_q, data_pend_d;
    logic [7:0] ec_rdata_q, ec_rdata_d;
    logic ec_ack_q, ec_ack_d;
    logic host_pend;

    assign host_pend = (req_sync2_q != ack_tgl_q);

    always_comb begin
        logic acc_ec;
        logic acc_host;
        logic acc_wr;
        logic acc_port;
        logic is_index;
        logic [7:0] acc_off;
        logic [7:0] acc_wdata;
        logic [7:0] rd_val;
        logic set_wr_flag;
        sel_t sel;
        acc_ec = 1'b0;
        acc_host = 1'b0;
        acc_wr = 1'b0;
        acc_port = 1'b0;
        is_index = 1'b0;
        acc_off = 8'h00;
        acc_wdata = 8'h00;
        rd_val = 8'h00;
        set_wr_flag = 1'b0;
        sel = '0;
        index_d = index_q;
        data_d = data_q;
        h2e_d = h2e_q;
        e2h_d = e2h_q;
        src_d = src_q;
        mask_d = mask_q;
        mbx_d = mbx_q;
        cmd_pend_d = cmd_pend_q;
        data_pend_d = data_pend_q;
        rsp_d = rsp_q;
        ack_tgl_d = ack_tgl_q;
        ec_rdata_d = ec_rdata_q;
        ec_ack_d = 1'b0;

        // EC clears first so a same-cycle host event still lands
        if (i_ec_irq_clr[0]) begin
            cmd_pend_d = 1'b0;
        end
        if (i_ec_irq_clr[1]) begin
            data_pend_d = 1'b0;
        end

        // EC has the single access slot; a waiting host access keeps its toggle
        acc_ec = i_ec_req;
        acc_host = host_pend & ~i_ec_req;
        acc_wr = acc_ec ? i_ec_wrote_flag : link_req_q.wr;
        acc_port = acc_ec ? i_ec_port_sel : 1'b1;
        acc_off = acc_ec ? i_ec_addr : {7'h00, link_req_q.addr};
        acc_wdata = acc_ec ? i_ec_wdata : link_req_q.data;
        is_index = acc_port && (acc_off[0] == PORT_OFF_INDEX);
        sel = acc_port ? decode_index(index_q) : decode_ec(acc_off);

        if (is_index) begin
            rd_val = index_q;
        end else if (sel.h2e) begin
            rd_val = h2e_q;
        end else if (sel.e2h) begin
            rd_val = e2h_q;
        end else if (sel.src) begin
            rd_val = src_q;
        end else if (sel.mask) begin
            rd_val = mask_q;
        end else if (sel.ec_command_irq) begin
            rd_val = mbx_q[sel.slot];
        end

        if (acc_ec || acc_host) begin
            if (acc_wr) begin
                if (is_index) begin
                    index_d = acc_wdata;
                end else begin
                    if (acc_port) begin
                        data_d = acc_wdata;
                    end
                    if (acc_host) begin
                        data_pend_d = 1'b1;
                    end
                    if (sel.h2e) begin
                        if (acc_port) begin
                            h2e_d = acc_wdata;
                            cmd_pend_d = cmd_pend_d | acc_host;
                        end else begin
                            h2e_d = (acc_wdata == CMD_CLEAR_VAL) ? CMD_CLEARED : acc_wdata;
                        end
                    end
                    if (sel.e2h) begin
                        if (acc_port) begin
                            e2h_d = (acc_wdata == CMD_CLEAR_VAL) ? CMD_CLEARED : acc_wdata;
                        end else begin
                            e2h_d = acc_wdata;
                            set_wr_flag = 1'b1;
                        end
                    end
                    if (sel.src) begin
                        if (acc_port) begin
                            src_d = src_q & ~acc_wdata;
                        end else begin
                            src_d[SMI_SWI_MSB:SMI_SWI_LSB] = acc_wdata[SMI_SWI_MSB:SMI_SWI_LSB];
                            src_d[SMI_WR_BIT] = src_q[SMI_WR_BIT] & ~acc_wdata[SMI_WR_BIT];
                        end
                    end
                    if (sel.mask) begin
                        mask_d = acc_wdata;
                    end
                    if (sel.ec_command_irq) begin
                        mbx_d[sel.slot] = acc_wdata;
                    end
                end
            end else if (acc_port && !is_index) begin
                data_d = rd_val;
            end
        end

        // Hardware set of the EC-wrote flag wins over any clear
        if (set_wr_flag) begin
            src_d[SMI_WR_BIT] = 1'b1;
        end

        if (acc_ec) begin
            ec_rdata_d = rd_val;
            ec_ack_d = 1'b1;
        end
        if (acc_host) begin
            rsp_d = rd_val;
            ack_tgl_d = ~ack_tgl_q;
        end

        if (!host_power_good_sync2_q) begin
            index_d = RST_BYTE;
            data_d = RST_BYTE;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            index_q <= RST_BYTE;
            data_q <= RST_BYTE;
            h2e_q <= RST_BYTE;
            e2h_q <= RST_BYTE;
            src_q <= RST_BYTE;
            mask_q <= RST_BYTE;
            for (int i = 0; i < MBX_COUNT; i++) begin
                mbx_q[i] <= RST_BYTE;
            end
            cmd_pend_q <= 1'b0;
            data_pend_q <= 1'b0;
            rsp_q <= RST_BYTE;
            ack_tgl_q <= 1'b0;
            ec_rdata_q <= RST_BYTE;
            ec_ack_q <= 1'b0;
        end else begin
            index_q <= index_d;
            data_q <= data_d;
            h2e_q <= h2e_d;
            e2h_q <= e2h_d;
            src_q <= src_d;
            mask_q <= mask_d;
            mbx_q <= mbx_d;
            cmd_pend_q <= cmd_pend_d;
            data_pend_q <= data_pend_d;
            rsp_q <= rsp_d;
            ack_tgl_q <= ack_tgl_d;
            ec_rdata_q <= ec_rdata_d;
            ec_ack_q <= ec_ack_d;
        end
    end

    assign o_ec_rdata = ec_rdata_q;
    assign o_ec_ack = ec_ack_q;

    // ---------------- Sys domain: event outputs ----------------
    logic cmd_irq_q, cmd_irq_d;
    logic data_irq_q, data_irq_d;
    logic serirq_q, serirq_d;
    logic smi_q, smi_d;
    logic [FRAME_COUNT-1:0] frame_vec_q, frame_vec_d;
    logic alert_oe_q, alert_oe_d;
    logic low_power_q, low_power_d;

    always_comb begin
        logic swi_hit;
        swi_hit = |(src_q[SMI_SWI_MSB:SMI_SWI_LSB] & mask_q[SMI_SWI_MSB:SMI_SWI_LSB]);
        cmd_irq_d = cmd_pend_q & i_ec_cmd_irq_en;
        data_irq_d = data_pend_q;
        serirq_d = src_q[SMI_WR_BIT] & mask_q[SMI_WR_BIT];
        smi_d = swi_hit | serirq_d;
        frame_vec_d = '0;
        frame_vec_d[i_smi_frame_sel] = smi_d;
        alert_oe_d = smi_d & i_alert_pin_sel;
        low_power_d = ~(i_ec_req | host_pend | smi_d | cmd_irq_d | data_irq_d);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd_irq_q <= 1'b0;
            data_irq_q <= 1'b0;
            serirq_q <= 1'b0;
            smi_q <= 1'b0;
            frame_vec_q <= '0;
            alert_oe_q <= 1'b0;
            low_power_q <= 1'b1;
        end else begin
            cmd_irq_q <= cmd_irq_d;
            data_irq_q <= data_irq_d;
            serirq_q <= serirq_d;
            smi_q <= smi_d;
            frame_vec_q <= frame_vec_d;
            alert_oe_q <= alert_oe_d;
            low_power_q <= low_power_d;
        end
    end

    assign o_ec_command_irq = cmd_irq_q;
    assign o_ec_data_irq = data_irq_q;
    assign o_host_serirq_source = serirq_q;
    assign o_host_smi_source = smi_q;
    assign o_smi_frame_vec = frame_vec_q;
    // Open drain: only ever pulls low
    assign o_host_alert_pin_out = 1'b0;
    assign o_host_alert_pin_oe = alert_oe_q;
    assign o_low_power = low_power_q;

endmodule : host_ec_mailbox

// >>> test/host_ec_mailbox_checker.sv
// Concurrent checks on the mailbox top-level ports
`timescale 1ns/1ps
module host_ec_mailbox_checker
    import mailbox_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_clk_link,
    input wire logic i_host_req,
    input wire logic o_host_busy,
    input wire logic o_host_done,
    input wire logic i_ec_req,
    input wire logic o_ec_ack,
    input wire logic i_ec_cmd_irq_en,
    input wire logic o_ec_command_irq,
    input wire logic o_host_serirq_source,
    input wire logic o_host_smi_source,
    input wire logic [3:0] i_smi_frame_sel,
    input wire logic [FRAME_COUNT-1:0] o_smi_frame_vec,
    input wire logic i_alert_pin_sel,
    input wire logic o_host_alert_pin_out,
    input wire logic o_host_alert_pin_oe,
    input wire logic o_low_power
);
    sequence s_host_take;
        i_host_req && !o_host_busy;
    endsequence

    sequence s_host_finish;
        o_host_busy ##[1:12] o_host_done;
    endsequence

    a_host_done_bound: assert property (@(posedge i_clk_link) disable iff (!i_rst_b)
        s_host_take |=> s_host_finish)
        else $error("host cycle not completed in time");
    a_ack_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ec_req |=> o_ec_ack)
        else $error("EC access not acknowledged");
    a_ack_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_ec_ack |-> $past(i_ec_req))
        else $error("EC ack without access");
    a_cmd_irq_mask: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_ec_command_irq |-> $past(i_ec_cmd_irq_en))
        else $error("command interrupt while masked");
    a_serirq_in_smi: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_host_serirq_source |-> o_host_smi_source)
        else $error("serial source without SMI source");
    a_frame_place: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_smi_frame_vec == (o_host_smi_source ? (16'h0001 << $past(i_smi_frame_sel)) : 16'h0000))
        else $error("SMI frame vector wrong");
    a_alert_drive_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_host_alert_pin_out == 1'b0)
        else $error("alert pin driven high");
    a_alert_select: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_host_alert_pin_oe |-> $past(i_alert_pin_sel) && o_host_smi_source)
        else $error("alert pin pulled without selection");
    a_idle_exit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_ec_req |=> !o_low_power)
        else $error("low power during access");
endmodule : host_ec_mailbox_checker

bind host_ec_mailbox host_ec_mailbox_checker u_host_ec_mailbox_checker (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_clk_link(i_clk_link),
    .i_host_req(i_host_req), .o_host_busy(o_host_busy), .o_host_done(o_host_done),
    .i_ec_req(i_ec_req), .o_ec_ack(o_ec_ack), .i_ec_cmd_irq_en(i_ec_cmd_irq_en),
    .o_ec_command_irq(o_ec_command_irq), .o_host_serirq_source(o_host_serirq_source),
    .o_host_smi_source(o_host_smi_source), .i_smi_frame_sel(i_smi_frame_sel),
    .o_smi_frame_vec(o_smi_frame_vec), .i_alert_pin_sel(i_alert_pin_sel),
    .o_host_alert_pin_out(o_host_alert_pin_out), .o_host_alert_pin_oe(o_host_alert_pin_oe),
    .o_low_power(o_low_power)
);

// >>> test/host_model.sv
// Host processor model issuing index/data port cycles on the link clock
`timescale 1ns/1ps
module host_model (
    input wire logic i_clk_link,
    input wire logic i_busy,
    input wire logic i_done,
    input wire logic [7:0] i_rdata,
    output logic o_req,
    output logic o_wr,
    output logic o_addr,
    output logic [7:0] o_wdata
);
    initial begin
        o_req = 1'b0;
        o_wr = 1'b0;
        o_addr = 1'b0;
        o_wdata = 8'h00;
    end

    task automatic access(input logic wr, input logic addr, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic ok);
        int n;
        @(posedge i_clk_link);
        #1;
        // Busy is looked at once it has settled after the edge
        while (i_busy === 1'b1) begin
            @(posedge i_clk_link);
            #1;
        end
        o_req = 1'b1;
        o_wr = wr;
        o_addr = addr;
        o_wdata = wdata;
        @(posedge i_clk_link);
        #1;
        o_req = 1'b0;
        // Released data lines do not keep the old byte
        o_wdata = ~wdata;
        ok = 1'b0;
        // Serialised: no new cycle before done, so command bytes are never clobbered
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge i_clk_link);
            #1;
            ok = (i_done === 1'b1);
        end
        rdata = i_rdata;
    endtask : access
endmodule : host_model

// >>> test/host_ec_mailbox_test.sv
// Self-checking bench for the host/EC mailbox
`timescale 1ns/1ps
module host_ec_mailbox_test;
    import mailbox_pkg::*;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic rst_b = 1'b0;
    logic pwr_good = 1'b1;
    logic ec_req = 1'b0, ec_wrote_flag = 1'b0, ec_ps = 1'b0, cmd_en = 1'b0, alert_sel = 1'b0, ok;
    logic [7:0] ec_addr = 8'h00, ec_wdata = 8'h00, rd;
    logic [1:0] irq_clr = 2'h0;
    logic [3:0] frame_sel = 4'h5;
    logic host_req, host_wr, host_addr, host_done, host_busy, ec_ack;
    logic cmd_irq, data_irq, serirq, smi, alert_out, alert_oe, low_power;
    logic [7:0] host_wdata, host_rdata, ec_rdata;
    logic [FRAME_COUNT-1:0] frame_vec;
    int num_errors = 0;
    int samples_checked = 0;

    always #5 clk_sys = ~clk_sys;
    always #40 clk_link = ~clk_link;

    host_ec_mailbox u_host_ec_mailbox (
        .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_clk_link(clk_link), .i_host_req(host_req),
        .i_host_wr(host_wr), .i_host_addr(host_addr), .i_host_wdata(host_wdata),
        .o_host_rdata(host_rdata), .o_host_done(host_done), .o_host_busy(host_busy),
        .i_host_power_good(pwr_good), .i_ec_req(ec_req), .i_ec_wrote_flag(ec_wrote_flag),
        .i_ec_port_sel(ec_ps), .i_ec_addr(ec_addr), .i_ec_wdata(ec_wdata),
        .o_ec_rdata(ec_rdata), .o_ec_ack(ec_ack), .i_ec_cmd_irq_en(cmd_en),
        .i_ec_irq_clr(irq_clr), .o_ec_command_irq(cmd_irq), .o_ec_data_irq(data_irq),
        .o_host_serirq_source(serirq), .o_host_smi_source(smi), .i_smi_frame_sel(frame_sel),
        .o_smi_frame_vec(frame_vec), .i_alert_pin_sel(alert_sel),
        .o_host_alert_pin_out(alert_out), .o_host_alert_pin_oe(alert_oe),
        .o_low_power(low_power)
    );

    host_model u_host_model (
        .i_clk_link(clk_link), .i_busy(host_busy), .i_done(host_done), .i_rdata(host_rdata),
        .o_req(host_req), .o_wr(host_wr), .o_addr(host_addr), .o_wdata(host_wdata)
    );

    task automatic test_done;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask : chk_bit

    task automatic wait_sys(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_sys

    task automatic ec(input logic wr, input logic ps, input logic [7:0] a, input logic [7:0] d);
        wait_sys(1);
        ec_req = 1'b1;
        ec_wrote_flag = wr;
        ec_ps = ps;
        ec_addr = a;
        ec_wdata = d;
        wait_sys(1);
        ec_req = 1'b0;
        ec_wdata = ~d;
        chk_bit(ec_ack, 1'b1);
        rd = ec_rdata;
    endtask : ec

    task automatic ew(input logic [7:0] a, input logic [7:0] d);
        ec(1'b1, 1'b0, a, d);
    endtask : ew

    task automatic er(input logic [7:0] a, input logic [7:0] exp);
        ec(1'b0, 1'b0, a, 8'h00);
        chk_val({8'h00, rd}, {8'h00, exp});
    endtask : er

    task automatic hw(input logic a, input logic [7:0] d);
        u_host_model.access(1'b1, a, d, rd, ok);
        chk_bit(ok, 1'b1);
    endtask : hw

    task automatic hr(input logic a, input logic [7:0] exp);
        u_host_model.access(1'b0, a, 8'h00, rd, ok);
        chk_bit(ok, 1'b1);
        chk_val({8'h00, rd}, {8'h00, exp});
    endtask : hr

    task automatic clr(input logic [1:0] v);
        wait_sys(1);
        irq_clr = v;
        wait_sys(1);
        irq_clr = 2'h0;
        wait_sys(3);
    endtask : clr

    initial begin
        #400000;
        num_errors++;
        test_done;
    end

    initial begin
        wait_sys(10);
        rst_b = 1'b1;
        wait_sys(3);
        chk_bit(low_power, 1'b1);
        hr(1'b0, 8'h00);
        hr(1'b1, 8'h00);
        hw(1'b0, 8'h84);
        hw(1'b1, 8'ha5);
        er(8'h10, 8'ha5);
        ew(8'h3a, 8'h5a);
        hw(1'b0, 8'hb3);
        hr(1'b1, 8'h5a);
        hr(1'b0, 8'hb3);
        chk_bit(data_irq, 1'b1);
        clr(2'h2);
        chk_bit(data_irq, 1'b0);
        for (int i = 0; i < 3; i++) begin
            hw(1'b0, 8'h9a + 8'(2 * i));
            hw(1'b1, 8'hff);
            hr(1'b1, 8'h00);
        end
        er(8'h24, 8'h00);
        cmd_en = 1'b1;
        hw(1'b0, 8'h82);
        hw(1'b1, 8'h3c);
        wait_sys(4);
        chk_bit(cmd_irq, 1'b1);
        er(8'h00, 8'h3c);
        ew(8'h00, 8'hff);
        er(8'h00, 8'h00);
        clr(2'h1);
        chk_bit(cmd_irq, 1'b0);
        cmd_en = 1'b0;
        hw(1'b1, 8'h11);
        wait_sys(4);
        chk_bit(cmd_irq, 1'b0);
        cmd_en = 1'b1;
        wait_sys(3);
        chk_bit(cmd_irq, 1'b1);
        clr(2'h1);
        ew(8'h0c, 8'h03);
        alert_sel = 1'b1;
        ew(8'h04, 8'h77);
        wait_sys(3);
        chk_bit(serirq, 1'b1);
        chk_bit(smi, 1'b1);
        chk_val(frame_vec, 16'h0020);
        chk_bit(alert_oe, 1'b1);
        chk_bit(alert_out, 1'b0);
        hw(1'b0, 8'h83);
        hr(1'b1, 8'h77);
        hw(1'b1, 8'hff);
        er(8'h04, 8'h00);
        hw(1'b0, 8'h96);
        hw(1'b1, 8'hff);
        wait_sys(3);
        chk_bit(serirq, 1'b0);
        ew(8'h08, 8'h02);
        wait_sys(3);
        chk_bit(smi, 1'b1);
        chk_bit(serirq, 1'b0);
        alert_sel = 1'b0;
        wait_sys(3);
        chk_bit(alert_oe, 1'b0);
        ew(8'h0c, 8'h01);
        wait_sys(3);
        chk_bit(smi, 1'b0);
        ec(1'b1, 1'b1, 8'h00, 8'h85);
        hr(1'b0, 8'h85);
        pwr_good = 1'b0;
        wait_sys(5);
        pwr_good = 1'b1;
        wait_sys(4);
        hr(1'b0, 8'h00);
        er(8'h10, 8'ha5);
        rst_b = 1'b0;
        repeat (3) @(posedge clk_link);
        wait_sys(1);
        chk_bit(low_power, 1'b1);
        rst_b = 1'b1;
        er(8'h10, 8'h00);
        test_done;
    end
endmodule : host_ec_mailbox_test
